// ==== hw/dsgc_consts.svh ====
`ifndef DSGC_CONSTS_SVH
`define DSGC_CONSTS_SVH
// -----------------------------------------------------------------
// sub-addresses
// -----------------------------------------------------------------
`define DSGC_ADDR_SYNC_LOCK    8'h04
`define DSGC_ADDR_ANALOG_IN    8'h05
`define DSGC_ADDR_CHROMA_PROC  8'h06
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define DSGC_RST_SYNC_LOCK     8'h09
`define DSGC_RST_ANALOG_IN     8'h10
`define DSGC_RST_CHROMA_PROC   8'h52
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define DSGC_BIT_ASPECT        7
`define DSGC_BIT_FREEZE        6
`define DSGC_BIT_DUTY          5
`define DSGC_BIT_LINE_TIMING   4
`define DSGC_BIT_MISS_H        3
`define DSGC_BIT_MISS_V        2
`define DSGC_BIT_AA_BYPASS     3
// -----------------------------------------------------------------
// missing-sync counts
// -----------------------------------------------------------------
`define DSGC_MISS_H_LONG       4'hC
`define DSGC_MISS_V_LONG       4'h3
`define DSGC_MISS_SHORT        4'h1
`endif

// ==== hw/dsgc_pkg.sv ====
package dsgc_pkg;
  typedef enum logic [2:0] {
    DSGC_FMT_YC16  = 3'h0,
    DSGC_FMT_YC8   = 3'h1,
    DSGC_FMT_BT656 = 3'h2,
    DSGC_FMT_RGB15 = 3'h3,
    DSGC_FMT_RGB16 = 3'h4
  } dsgc_fmt_type;

  typedef enum logic [1:0] {
    DSGC_GAIN_UNITY  = 2'h0,
    DSGC_GAIN_AUTO   = 2'h1,
    DSGC_GAIN_FIXED  = 2'h2,
    DSGC_GAIN_FREEZE = 2'h3
  } dsgc_gain_type;

  typedef struct packed {
    logic       write;
    logic [7:0] address;
    logic [7:0] data;
  } dsgc_req_type;

  typedef struct packed {
    logic       square_pixel;
    logic       timing_frozen;
    logic       anti_alias_bypass;
    logic [2:0] input_select;
    logic [1:0] input_clock_code;
    logic [1:0] chroma_gain_mode;
    logic [1:0] colour_killer_mode;
    logic [1:0] chroma_coring;
    logic       contrast_on_chroma;
    logic       chroma_wide_band;
  } dsgc_cfg_type;
endpackage : dsgc_pkg

// ==== hw/dsgc_regs.sv ====
`timescale 1ns/1ps
`include "dsgc_consts.svh"
// Contract
// - bit 7 selects rectangular (0) or square (1) pixel sampling, reset 0.
// - freeze bit set holds output timing from the end of current field.
// - freeze bit cleared resumes normal timing at start of next field.
// - wide modes: duty bit 0 square-wave strobe, 1 line-lock strobe; ignored narrow.
// - wide modes: line bit 0 active video only, 1 whole line every line.
// - narrow modes: line bit 0 normal strobe, 1 strobe ANDed with input clock.
// - horizontal reacquire after 12 missing pulses (0) or 1 (1), reset 1.
// - vertical reacquire after 3 missing pulses (0) or 1 (1), reset 0.
// - lock-loss field ignored while gain mode equals automatic.
// - lock-loss code 00 on sync loss rewrites gain mode to automatic.
// - code 01 keeps gain; 10 runs auto then fixed, resets only freeze; after lock the code returns to the gain field mode.
// - gain mode: unity, automatic, fixed from adjust register, freeze; reset 01.
// - bit 3 bypasses the anti-alias filter when 1, reset 0.
// - chroma gain mode: unity, auto, fixed, freeze; reset 01.
// - chroma coring by 0 to 3 codes, reset 00.
// - contrast scope luma only (0) or luma and chroma (1), reset 1.
// - chroma low-pass 850kHz (0) or 1.5MHz (1), reset 0.
module dsgc_regs #(
  parameter int MISS_WIDTH = 4
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire dsgc_pkg::dsgc_req_type request,
  input  wire logic                  request_valid,
  input  wire dsgc_pkg::dsgc_fmt_type output_format,
  input  wire logic                  field_start,
  input  wire logic                  line_start,
  input  wire logic                  active_video,
  input  wire logic                  active_line,
  input  wire logic                  pixel_tick,
  input  wire logic                  line_lock_tick,
  input  wire logic                  double_rate_input_clock,
  input  wire logic                  hsync_expected,
  input  wire logic                  hsync_seen,
  input  wire logic                  vsync_expected,
  input  wire logic                  vsync_seen,
  input  wire logic                  sync_lost,
  input  wire logic                  lock_achieved,
  output logic [7:0]                 read_data,
  output dsgc_pkg::dsgc_cfg_type     config_out,
  output dsgc_pkg::dsgc_gain_type    video_gain_mode,
  output logic                       pixel_valid_strobe,
  output logic                       horiz_acquire,
  output logic                       vert_acquire
);
  import dsgc_pkg::*;

  if (MISS_WIDTH < 4) begin : g_width_check
    $error("MISS_WIDTH must hold a count of 12");
  end

  // -----------------------------------------------------------------
  // register storage
  // -----------------------------------------------------------------
  logic [7:0]    sync_lock_control;
  logic [7:0]    analog_input_control;
  logic [7:0]    chroma_processing_config;
  logic          wr_sync;
  logic          wr_analog;
  logic          wr_chroma;
  logic          fixed_after_lock;
  logic          start_hold;
  dsgc_gain_type next_gain;

  assign wr_sync   = request_valid && request.write
                     && request.address == `DSGC_ADDR_SYNC_LOCK;
  assign wr_analog = request_valid && request.write
                     && request.address == `DSGC_ADDR_ANALOG_IN;
  assign wr_chroma = request_valid && request.write
                     && request.address == `DSGC_ADDR_CHROMA_PROC;
  assign start_hold = sync_lost && analog_input_control[7:6] == 2'h2
                      && analog_input_control[5:4] != 2'h1;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync_lock_control        <= `DSGC_RST_SYNC_LOCK;
      chroma_processing_config <= `DSGC_RST_CHROMA_PROC;
    end else begin
      if (wr_sync) begin
        sync_lock_control <= request.data;
      end
      if (wr_chroma) begin
        chroma_processing_config <= request.data;
      end
    end
  end

  // gain mode field with hardware rewrite on sync loss
  always_comb begin
    next_gain = dsgc_gain_type'(analog_input_control[5:4]);
    if (sync_lost && next_gain != DSGC_GAIN_AUTO) begin
      unique case (analog_input_control[7:6])
        2'h0: next_gain = DSGC_GAIN_AUTO;
        2'h2: begin
          if (next_gain == DSGC_GAIN_FREEZE) next_gain = DSGC_GAIN_AUTO;
        end
        default: next_gain = dsgc_gain_type'(analog_input_control[5:4]);
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      analog_input_control <= `DSGC_RST_ANALOG_IN;
    end else if (wr_analog) begin
      analog_input_control <= request.data;
    end else begin
      analog_input_control[5:4] <= next_gain;
    end
  end

  // code 10: automatic gain until lock returns, then the gain field mode
  always_ff @(posedge clock) begin
    if (reset) begin
      fixed_after_lock <= 1'b0;
    end else if (start_hold) begin
      fixed_after_lock <= 1'b1;
    end else if (lock_achieved || wr_analog) begin
      fixed_after_lock <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      video_gain_mode <= DSGC_GAIN_AUTO;
    end else if (fixed_after_lock || start_hold) begin
      video_gain_mode <= DSGC_GAIN_AUTO;
    end else begin
      video_gain_mode <= next_gain;
    end
  end

  // -----------------------------------------------------------------
  // read port
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= 8'h00;
    end else if (request_valid && !request.write) begin
      unique case (request.address)
        `DSGC_ADDR_SYNC_LOCK:   read_data <= sync_lock_control;
        `DSGC_ADDR_ANALOG_IN:   read_data <= analog_input_control;
        `DSGC_ADDR_CHROMA_PROC: read_data <= chroma_processing_config;
        default:                read_data <= 8'h00;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // configuration outputs
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      config_out.timing_frozen      <= 1'b0;
      config_out.square_pixel       <= 1'b0;
      config_out.anti_alias_bypass  <= 1'b0;
      config_out.input_select       <= 3'h0;
      config_out.input_clock_code   <= 2'h1;
      config_out.chroma_gain_mode   <= 2'h1;
      config_out.colour_killer_mode <= 2'h1;
      config_out.chroma_coring      <= 2'h0;
      config_out.contrast_on_chroma <= 1'b1;
      config_out.chroma_wide_band   <= 1'b0;
    end else begin
      if (field_start) begin
        config_out.timing_frozen    <= sync_lock_control[`DSGC_BIT_FREEZE];
      end
      config_out.square_pixel       <= sync_lock_control[`DSGC_BIT_ASPECT];
      config_out.anti_alias_bypass  <= analog_input_control[`DSGC_BIT_AA_BYPASS];
      config_out.input_select       <= analog_input_control[2:0];
      config_out.input_clock_code   <= sync_lock_control[1:0];
      config_out.chroma_gain_mode   <= chroma_processing_config[7:6];
      config_out.colour_killer_mode <= chroma_processing_config[5:4];
      config_out.chroma_coring      <= chroma_processing_config[3:2];
      config_out.contrast_on_chroma <= chroma_processing_config[1];
      config_out.chroma_wide_band   <= chroma_processing_config[0];
    end
  end

  // -----------------------------------------------------------------
  // pixel-valid strobe
  // -----------------------------------------------------------------
  logic wide_mode;
  logic square_phase;
  logic next_strobe;
  assign wide_mode = output_format == DSGC_FMT_YC16 || output_format == DSGC_FMT_RGB15
                     || output_format == DSGC_FMT_RGB16;

  always_ff @(posedge clock) begin
    if (reset || line_start) begin
      square_phase <= 1'b0;
    end else if (pixel_tick) begin
      square_phase <= ~square_phase;
    end
  end

  always_comb begin
    if (wide_mode) begin
      next_strobe = sync_lock_control[`DSGC_BIT_DUTY] ? line_lock_tick
                                                      : square_phase;
      if (!sync_lock_control[`DSGC_BIT_LINE_TIMING]) begin
        next_strobe = next_strobe && active_video && active_line;
      end
    end else begin
      next_strobe = active_video && active_line;
      if (sync_lock_control[`DSGC_BIT_LINE_TIMING]) begin
        next_strobe = next_strobe && double_rate_input_clock;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pixel_valid_strobe <= 1'b0;
    end else begin
      pixel_valid_strobe <= next_strobe;
    end
  end

  // -----------------------------------------------------------------
  // missing-sync counters
  // -----------------------------------------------------------------
  logic [MISS_WIDTH-1:0] h_missing;
  logic [MISS_WIDTH-1:0] v_missing;
  logic [MISS_WIDTH-1:0] h_limit;
  logic [MISS_WIDTH-1:0] v_limit;
  assign h_limit = sync_lock_control[`DSGC_BIT_MISS_H] ? MISS_WIDTH'(`DSGC_MISS_SHORT)
                                                       : MISS_WIDTH'(`DSGC_MISS_H_LONG);
  assign v_limit = sync_lock_control[`DSGC_BIT_MISS_V] ? MISS_WIDTH'(`DSGC_MISS_SHORT)
                                                       : MISS_WIDTH'(`DSGC_MISS_V_LONG);

  always_ff @(posedge clock) begin
    if (reset || hsync_seen) begin
      h_missing     <= '0;
      horiz_acquire <= 1'b0;
    end else if (hsync_expected) begin
      if (h_missing + 1'b1 >= h_limit) begin
        horiz_acquire <= 1'b1;
        h_missing     <= '0;
      end else begin
        h_missing     <= h_missing + 1'b1;
        horiz_acquire <= 1'b0;
      end
    end else begin
      horiz_acquire <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || vsync_seen) begin
      v_missing    <= '0;
      vert_acquire <= 1'b0;
    end else if (vsync_expected) begin
      if (v_missing + 1'b1 >= v_limit) begin
        vert_acquire <= 1'b1;
        v_missing    <= '0;
      end else begin
        v_missing    <= v_missing + 1'b1;
        vert_acquire <= 1'b0;
      end
    end else begin
      vert_acquire <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  freeze_follow_a: assert property (@(posedge clock) disable iff (reset)
    field_start |=> config_out.timing_frozen == $past(sync_lock_control[6]))
    else $error("freeze not taken at field start");
  freeze_hold_a: assert property (@(posedge clock) disable iff (reset)
    !field_start |=> $stable(config_out.timing_frozen))
    else $error("freeze changed mid field");
  gain_auto_a: assert property (@(posedge clock) disable iff (reset)
    sync_lost && !wr_analog && analog_input_control[7:4] == 4'h0
    |=> analog_input_control[5:4] == 2'h1)
    else $error("gain mode not rewritten to automatic");
  gain_ignored_a: assert property (@(posedge clock) disable iff (reset)
    !wr_analog && analog_input_control[5:4] == 2'h1 |=> analog_input_control[5:4] == 2'h1)
    else $error("automatic gain mode changed by lock loss");
  gain_keep_a: assert property (@(posedge clock) disable iff (reset)
    !wr_analog && analog_input_control[7:6] == 2'h1 |=> $stable(analog_input_control[5:4]))
    else $error("code 01 changed gain mode");
  horiz_short_a: assert property (@(posedge clock) disable iff (reset)
    sync_lock_control[3] && hsync_expected && !hsync_seen |=> horiz_acquire)
    else $error("one missing hsync not acted on");
  vert_short_a: assert property (@(posedge clock) disable iff (reset)
    sync_lock_control[2] && vsync_expected && !vsync_seen |=> vert_acquire)
    else $error("one missing vsync not acted on");
  line_video_a: assert property (@(posedge clock) disable iff (reset)
    wide_mode && !sync_lock_control[4] && !active_video |=> !pixel_valid_strobe)
    else $error("strobe outside active video");
  aspect_a: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> config_out.square_pixel == $past(sync_lock_control[7]))
    else $error("aspect mode not forwarded");
endmodule : dsgc_regs

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "dsgc_consts.svh"
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t %s", $time, msg); end end
module tb_top;
  import dsgc_pkg::*;
  // -----------------------------------------------------------------
  // stimulus and observed signals
  // -----------------------------------------------------------------
  logic           clock = 1'b0;
  logic           reset = 1'b1;
  dsgc_req_type   request = '0;
  logic           request_valid = 1'b0;
  dsgc_fmt_type   output_format = DSGC_FMT_YC16;
  logic           field_start = 1'b0, line_start = 1'b0;
  logic           active_video = 1'b0, active_line = 1'b0;
  logic           pixel_tick = 1'b0, line_lock_tick = 1'b0;
  logic           double_rate_input_clock = 1'b0;
  logic           hsync_expected = 1'b0, hsync_seen = 1'b0;
  logic           vsync_expected = 1'b0, vsync_seen = 1'b0;
  logic           sync_lost = 1'b0, lock_achieved = 1'b0;
  logic [7:0]     read_data;
  dsgc_cfg_type   config_out;
  dsgc_gain_type  video_gain_mode;
  logic           pixel_valid_strobe, horiz_acquire, vert_acquire;
  int             err_total = 0, checks_done = 0, cycles = 0;
  int             h_cnt = 0, v_cnt = 0, tog = 0;
  logic           last_strobe = 1'b0;

  dsgc_regs dut_u (.clock(clock), .reset(reset), .request(request),
    .request_valid(request_valid), .output_format(output_format),
    .field_start(field_start), .line_start(line_start), .active_video(active_video),
    .active_line(active_line), .pixel_tick(pixel_tick), .line_lock_tick(line_lock_tick),
    .double_rate_input_clock(double_rate_input_clock), .hsync_expected(hsync_expected),
    .hsync_seen(hsync_seen), .vsync_expected(vsync_expected), .vsync_seen(vsync_seen),
    .sync_lost(sync_lost), .lock_achieved(lock_achieved), .read_data(read_data),
    .config_out(config_out), .video_gain_mode(video_gain_mode),
    .pixel_valid_strobe(pixel_valid_strobe), .horiz_acquire(horiz_acquire),
    .vert_acquire(vert_acquire));

  always #5 clock = ~clock;

  // -----------------------------------------------------------------
  // monitors and timeout
  // -----------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (horiz_acquire === 1'b1) h_cnt++;
    if (vert_acquire === 1'b1) v_cnt++;
    if (pixel_valid_strobe !== last_strobe) tog++;
    last_strobe = pixel_valid_strobe;
    if (cycles == 5000) begin
      err_total++;
      end_sim();
    end
  end

  // -----------------------------------------------------------------
  // bus and helper tasks
  // -----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    request = '{write: 1'b1, address: a, data: d};
    request_valid = 1'b1;
    tick(1);
    request_valid = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    request = '{write: 1'b0, address: a, data: 8'h00};
    request_valid = 1'b1;
    tick(1);
    request_valid = 1'b0;
    tick(1);
    `CHK(read_data, exp, msg)
  endtask : rd

  task automatic miss(input logic horiz, input int n);
    repeat (n) begin
      hsync_expected = horiz;
      vsync_expected = !horiz;
      tick(1);
      hsync_expected = 1'b0;
      vsync_expected = 1'b0;
      tick(2);
    end
  endtask : miss

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset_values();
    rd(`DSGC_ADDR_SYNC_LOCK, 8'h09, "sync lock reset");
    rd(`DSGC_ADDR_ANALOG_IN, 8'h10, "analog input reset");
    rd(`DSGC_ADDR_CHROMA_PROC, 8'h52, "chroma reset");
    rd(8'h07, 8'h00, "unmapped read");
    `CHK(video_gain_mode, DSGC_GAIN_AUTO, "gain mode reset")
    `CHK(config_out.contrast_on_chroma, 1'b1, "contrast scope reset")
  endtask : t_reset_values

  task automatic t_fields();
    wr(`DSGC_ADDR_SYNC_LOCK, 8'hAA);
    wr(`DSGC_ADDR_ANALOG_IN, 8'h4C);
    wr(`DSGC_ADDR_CHROMA_PROC, 8'hBD);
    wr(8'h07, 8'hFF);
    tick(2);
    `CHK(config_out.square_pixel, 1'b1, "square pixel")
    `CHK(config_out.input_clock_code, 2'h2, "clock code 29.5")
    `CHK(config_out.anti_alias_bypass, 1'b1, "filter bypass")
    `CHK(config_out.input_select, 3'h4, "reserved input select")
    `CHK(video_gain_mode, DSGC_GAIN_UNITY, "unity gain")
    `CHK(config_out.chroma_gain_mode, 2'h2, "chroma fixed gain")
    `CHK(config_out.colour_killer_mode, 2'h3, "colour off")
    `CHK(config_out.chroma_coring, 2'h3, "coring three")
    `CHK(config_out.contrast_on_chroma, 1'b0, "contrast luma only")
    `CHK(config_out.chroma_wide_band, 1'b1, "wide chroma band")
    rd(`DSGC_ADDR_SYNC_LOCK, 8'hAA, "sync lock readback");
    rd(8'h07, 8'h00, "unmapped write ignored");
    wr(`DSGC_ADDR_SYNC_LOCK, 8'h09);
    wr(`DSGC_ADDR_ANALOG_IN, 8'h03);
    wr(`DSGC_ADDR_CHROMA_PROC, 8'h62);
    tick(2);
    `CHK(config_out.square_pixel, 1'b0, "rectangular pixel")
    `CHK(config_out.input_select, 3'h3, "separate luma chroma")
    `CHK(config_out.anti_alias_bypass, 1'b0, "filter in path")
    `CHK(config_out.colour_killer_mode, 2'h2, "reserved killer code")
    `CHK(config_out.chroma_wide_band, 1'b0, "narrow chroma band")
  endtask : t_fields

  task automatic t_freeze();
    wr(`DSGC_ADDR_SYNC_LOCK, 8'h49);
    tick(3);
    `CHK(config_out.timing_frozen, 1'b0, "freeze waits for field")
    field_start = 1'b1;
    tick(1);
    field_start = 1'b0;
    tick(2);
    `CHK(config_out.timing_frozen, 1'b1, "frozen at field end")
    wr(`DSGC_ADDR_SYNC_LOCK, 8'h09);
    tick(3);
    `CHK(config_out.timing_frozen, 1'b1, "release waits for field")
    field_start = 1'b1;
    tick(1);
    field_start = 1'b0;
    tick(2);
    `CHK(config_out.timing_frozen, 1'b0, "released at next field")
  endtask : t_freeze

  task automatic t_missing();
    miss(1'b1, 1);
    `CHK(h_cnt, 1, "one missing hsync")
    wr(`DSGC_ADDR_SYNC_LOCK, 8'h01);
    miss(1'b1, 11);
    `CHK(h_cnt, 1, "eleven missing hsync")
    miss(1'b1, 1);
    `CHK(h_cnt, 2, "twelve missing hsync")
    miss(1'b0, 2);
    `CHK(v_cnt, 0, "two missing vsync")
    miss(1'b0, 1);
    `CHK(v_cnt, 1, "three missing vsync")
    wr(`DSGC_ADDR_SYNC_LOCK, 8'h05);
    miss(1'b0, 1);
    `CHK(v_cnt, 2, "one missing vsync short")
    miss(1'b1, 11);
    hsync_seen = 1'b1;
    tick(1);
    hsync_seen = 1'b0;
    miss(1'b1, 1);
    `CHK(h_cnt, 2, "seen hsync restarts count")
    wr(`DSGC_ADDR_SYNC_LOCK, 8'h01);
    miss(1'b0, 2);
    vsync_seen = 1'b1;
    tick(1);
    vsync_seen = 1'b0;
    miss(1'b0, 1);
    `CHK(v_cnt, 2, "seen vsync restarts count")
  endtask : t_missing

  task automatic t_gain();
    logic [7:0]    wv[5] = '{8'h00, 8'h60, 8'hB0, 8'h10, 8'hA0};
    logic [7:0]    rv[5] = '{8'h10, 8'h60, 8'h90, 8'h10, 8'hA0};
    dsgc_gain_type gv[5] = '{DSGC_GAIN_AUTO, DSGC_GAIN_FIXED, DSGC_GAIN_AUTO,
                             DSGC_GAIN_AUTO, DSGC_GAIN_AUTO};
    for (int i = 0; i < 5; i++) begin
      wr(`DSGC_ADDR_ANALOG_IN, wv[i]);
      sync_lost = 1'b1;
      tick(2);
      sync_lost = 1'b0;
      tick(2);
      rd(`DSGC_ADDR_ANALOG_IN, rv[i], "gain field after loss");
      `CHK(video_gain_mode, gv[i], "gain mode after loss")
    end
    lock_achieved = 1'b1;
    tick(1);
    lock_achieved = 1'b0;
    tick(2);
    `CHK(video_gain_mode, DSGC_GAIN_FIXED, "fixed after lock")
  endtask : t_gain

  task automatic t_strobe(input dsgc_fmt_type f, input logic [7:0] v, input logic act,
                          input logic moves);
    output_format = f;
    active_video = act;
    active_line = act;
    wr(`DSGC_ADDR_SYNC_LOCK, v);
    tick(3);
    tog = 0;
    repeat (8) begin
      pixel_tick = 1'b1;
      double_rate_input_clock = 1'b1;
      tick(1);
      pixel_tick = 1'b0;
      double_rate_input_clock = 1'b0;
      tick(1);
    end
    `CHK(tog > 0, moves, "strobe activity")
  endtask : t_strobe

  task automatic t_reset_mid();
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    t_reset_values();
  endtask : t_reset_mid

  task automatic end_sim();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  initial begin
    tick(8);
    reset = 1'b0;
    t_reset_values();
    t_fields();
    t_freeze();
    t_missing();
    t_gain();
    t_strobe(DSGC_FMT_YC16, 8'h09, 1'b0, 1'b0);
    t_strobe(DSGC_FMT_RGB16, 8'h19, 1'b0, 1'b1);
    t_strobe(DSGC_FMT_RGB15, 8'h39, 1'b0, 1'b0);
    t_strobe(DSGC_FMT_BT656, 8'h19, 1'b1, 1'b1);
    t_strobe(DSGC_FMT_YC8, 8'h29, 1'b1, 1'b0);
    t_reset_mid();
    end_sim();
  end
endmodule : tb_top
